// ---- mpfv_consts.svh ----
/*
 * Register indices, fields, resets and timing counts.
 * Assumes a 10 MHz pclk.
 */
// Notes on behaviour
// - pass-control set: valid pause frame sets the packet filter bit.
// - pass-control clear: pause frames leave the packet filter bit clear.
// - all received frame data reaches the application, errors included.
// - flow enable: decode pause frames, hold transmitter quanta times slot.
// - flow enable clear: no pause decode, no hold-off, no backpressure; pause frames can still be sent.
// - pause in full duplex only; half duplex enable means backpressure.
// - busy high while pause frame sent or backpressure applied.
// - busy clears when the pause frame has gone out.
// - bytes 13 and 14 matching tag identifier mark a tagged frame.
// - tagged frames may be 1522 bytes instead of 1518.
// - pause time field goes into every sent pause frame.
// - transmitter disabled: no new pause frames, no backpressure; a pause frame already started still finishes.
`ifndef MPFV_CONSTS_SVH
`define MPFV_CONSTS_SVH

// ========================================
// register indices; byte address = 4 x index
`define MPFV_IDX_FLOW       8
`define MPFV_IDX_TAG1       9
`define MPFV_IDX_CTRL       16
`define MPFV_IDX_STAT       17
`define MPFV_IDX_IRQ_STAT   18
`define MPFV_IDX_IRQ_MASK   19

// ========================================
// fields
`define MPFV_FLOW_PT_LSB    16
`define MPFV_FLOW_PASS      2
`define MPFV_FLOW_EN        1
`define MPFV_FLOW_BUSY      0
`define MPFV_CTRL_TXEN      0
`define MPFV_CTRL_FDX       1
`define MPFV_CTRL_SPD100    2
`define MPFV_CTRL_SENDP     3
`define MPFV_CTRL_BPREQ     4
`define MPFV_FLOW_RST       32'h0000_0000
`define MPFV_TAG1_RST       32'h0000_0000
`define MPFV_CTRL_RST       32'h0000_0000

// ========================================
// frame constants
`define MPFV_MAX_LEN        1518
`define MPFV_MAX_LEN_TAG    1522
`define MPFV_PAUSE_TYPE     16'h8808
`define MPFV_PAUSE_OPC      16'h0001
`define MPFV_PAUSE_DA       48'h0180_C200_0001

// ========================================
// timing: slot of 512 bit times, rounded up to whole clocks
`define MPFV_CLK_NS         100
`define MPFV_SLOT_NS_100    5120
`define MPFV_SLOT_NS_10     51200
`define MPFV_SLOT_CYC_100   ((`MPFV_SLOT_NS_100 + `MPFV_CLK_NS - 1) / `MPFV_CLK_NS)
`define MPFV_SLOT_CYC_10    ((`MPFV_SLOT_NS_10 + `MPFV_CLK_NS - 1) / `MPFV_CLK_NS)

`endif

// ---- mpfv_pkg.sv ----
/*
 * Shared types of the flow-control block.
 * Assumes nothing.
 */
package mpfv_pkg;
    // ========================================
    // transmit-side flow states
    typedef enum logic [1:0] {
        MPFV_IDLE,
        MPFV_SEND,
        MPFV_BACKP
    } mpfv_flow_st_t;

    typedef logic [15:0] mpfv_quanta_t;
endpackage : mpfv_pkg

// ---- mpfv_rx_parse.sv ----
/*
 * Receive parser: pause decode, tag detect, length check.
 * Assumes one byte per rx_valid.
 */
`timescale 1ns/100ps
`include "mpfv_consts.svh"
module mpfv_rx_parse (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  rx_valid,
    input  wire logic [7:0]            rx_data,
    input  wire logic                  rx_sof,
    input  wire logic                  rx_eof,
    input  wire logic                  rx_err,
    input  wire logic                  decode_en,
    input  wire logic [15:0]           tag_id,
    output logic                       done_r,
    output logic                       pause_ok_r,
    output mpfv_pkg::mpfv_quanta_t     quanta_r,
    output logic                       tagged_r,
    output logic                       too_long_r,
    output logic [15:0]                len_r
);
    import mpfv_pkg::*;

    logic [15:0]  idx_r;
    logic [47:0]  da_r;
    logic [15:0]  w_r;
    logic         type_ok_r;
    logic         opc_ok_r;
    logic         tag_r;
    logic [15:0]  idx;
    logic [15:0]  w_nxt;
    logic [15:0]  limit;

    // ========================================
    // byte position and sliding header word
    assign idx   = rx_sof ? 16'h0000 : idx_r;
    assign w_nxt = {w_r[7:0], rx_data};
    assign limit = (tag_r || (idx == 16'd13 && w_nxt == tag_id)) ?
                   16'(`MPFV_MAX_LEN_TAG) : 16'(`MPFV_MAX_LEN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_r <= 16'h0000;
            w_r   <= 16'h0000;
            da_r  <= 48'h0000_0000_0000;
        end else if (rx_valid) begin
            idx_r <= idx + 16'd1;
            w_r   <= w_nxt;
            if (idx < 16'd6) begin
                da_r <= {da_r[39:0], rx_data};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            type_ok_r <= 1'b0;
            opc_ok_r  <= 1'b0;
            tag_r     <= 1'b0;
            quanta_r  <= 16'h0000;
        end else if (rx_valid) begin
            if (idx == 16'd13) begin
                tag_r     <= (w_nxt == tag_id);
                type_ok_r <= (w_nxt == `MPFV_PAUSE_TYPE) && (da_r == `MPFV_PAUSE_DA);
            end else if (rx_sof) begin
                tag_r     <= 1'b0;
                type_ok_r <= 1'b0;
            end
            if (idx == 16'd15) begin
                opc_ok_r <= (w_nxt == `MPFV_PAUSE_OPC);
            end else if (rx_sof) begin
                opc_ok_r <= 1'b0;
            end
            if (idx == 16'd17) begin
                quanta_r <= w_nxt;
            end
        end
    end

    // ========================================
    // one-cycle report at the end of each frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r     <= 1'b0;
            pause_ok_r <= 1'b0;
            tagged_r   <= 1'b0;
            too_long_r <= 1'b0;
            len_r      <= 16'h0000;
        end else begin
            done_r <= rx_valid && rx_eof;
            if (rx_valid && rx_eof) begin
                // decode off means no control frame is ever recognised
                pause_ok_r <= decode_en && type_ok_r && opc_ok_r && !rx_err
                              && idx >= 16'd17;
                tagged_r   <= tag_r;
                too_long_r <= (idx + 16'd1) > limit;
                len_r      <= 16'(idx + 16'd1);
            end
        end
    end
endmodule : mpfv_rx_parse

// ---- mpfv_tx_flow.sv ----
/*
 * Transmit flow control: pause hold-off, send, backpressure.
 * Assumes a done pulse per sent pause frame.
 */
`timescale 1ns/100ps
`include "mpfv_consts.svh"
module mpfv_tx_flow (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  tx_enable,
    input  wire logic                  full_duplex,
    input  wire logic                  speed100,
    input  wire logic                  flow_en,
    input  wire logic                  send_pause,
    input  wire logic                  bp_request,
    input  wire logic                  pause_rx,
    input  wire mpfv_pkg::mpfv_quanta_t pause_rx_quanta,
    input  wire logic                  pause_tx_done,
    output logic                       busy_r,
    output logic                       pause_tx_req_r,
    output logic                       backpressure_r,
    output logic                       tx_hold_r,
    output logic                       sent_r
);
    import mpfv_pkg::*;

    mpfv_flow_st_t st_r;
    mpfv_quanta_t  quanta_left_r;
    logic [9:0]    slot_cnt_r;
    logic [9:0]    slot_last;

    assign slot_last = speed100 ? 10'(`MPFV_SLOT_CYC_100 - 1) :
                                  10'(`MPFV_SLOT_CYC_10 - 1);

    // ========================================
    // hold-off after a received pause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quanta_left_r <= 16'h0000;
            slot_cnt_r    <= 10'h000;
            tx_hold_r     <= 1'b0;
        end else if (!flow_en || !full_duplex) begin
            quanta_left_r <= 16'h0000;
            slot_cnt_r    <= 10'h000;
            tx_hold_r     <= 1'b0;
        end else if (pause_rx) begin
            quanta_left_r <= pause_rx_quanta;
            slot_cnt_r    <= 10'h000;
            tx_hold_r     <= (pause_rx_quanta != 16'h0000);
        end else if (quanta_left_r != 16'h0000) begin
            if (slot_cnt_r == slot_last) begin
                slot_cnt_r    <= 10'h000;
                quanta_left_r <= quanta_left_r - 16'd1;
                tx_hold_r     <= (quanta_left_r != 16'd1);
            end else begin
                slot_cnt_r <= slot_cnt_r + 10'd1;
            end
        end
    end

    // ========================================
    // pause send and backpressure; busy is owned here only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r           <= MPFV_IDLE;
            busy_r         <= 1'b0;
            pause_tx_req_r <= 1'b0;
            backpressure_r <= 1'b0;
            sent_r         <= 1'b0;
        end else begin
            sent_r <= 1'b0;
            case (st_r)
                MPFV_IDLE: begin
                    if (tx_enable && full_duplex && send_pause) begin
                        st_r           <= MPFV_SEND;
                        busy_r         <= 1'b1;
                        pause_tx_req_r <= 1'b1;
                    end else if (tx_enable && !full_duplex && flow_en && bp_request) begin
                        st_r           <= MPFV_BACKP;
                        busy_r         <= 1'b1;
                        backpressure_r <= 1'b1;
                    end
                end
                MPFV_SEND: begin
                    // a started frame finishes even if tx drops
                    if (pause_tx_done) begin
                        st_r           <= MPFV_IDLE;
                        busy_r         <= 1'b0;
                        pause_tx_req_r <= 1'b0;
                        sent_r         <= 1'b1;
                    end
                end
                MPFV_BACKP: begin
                    if (!tx_enable || full_duplex || !flow_en || !bp_request) begin
                        st_r           <= MPFV_IDLE;
                        busy_r         <= 1'b0;
                        backpressure_r <= 1'b0;
                    end
                end
                default: begin
                    st_r           <= MPFV_IDLE;
                    busy_r         <= 1'b0;
                    pause_tx_req_r <= 1'b0;
                    backpressure_r <= 1'b0;
                end
            endcase
        end
    end
endmodule : mpfv_tx_flow

// ---- mpfv_top.sv ----
/*
 * Flow-control and tag-detect block with APB slave.
 * Assumes a MAC transmitter that pulses done per pause frame.
 */
// Local design decision: the APB register port.
`timescale 1ns/100ps
`include "mpfv_consts.svh"
module mpfv_top (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire logic                  rx_valid,
    input  wire logic [7:0]            rx_data,
    input  wire logic                  rx_sof,
    input  wire logic                  rx_eof,
    input  wire logic                  rx_err,
    input  wire logic                  rx_addr_fail,
    output logic                       app_valid,
    output logic [7:0]                 app_data,
    output logic                       app_sof,
    output logic                       app_eof,
    output logic                       app_stat_valid,
    output logic [31:0]                app_stat,
    input  wire logic                  pause_tx_done,
    output logic                       pause_tx_req,
    output logic [15:0]                pause_tx_time,
    output logic                       backpressure,
    output logic                       tx_hold,
    output logic                       irq
);
    import mpfv_pkg::*;

    // ========================================
    // registers
    logic [31:0]   flow_r;
    logic [15:0]   tag1_r;
    logic [4:0]    ctrl_r;
    logic [3:0]    irq_stat_r;
    logic [3:0]    irq_mask_r;
    logic          pready_r;
    logic [31:0]   prdata_r;
    logic          pslverr_r;
    logic [31:0]   rd_nxt;
    logic          rd_ok;
    logic          wr_done;
    logic          rd_done;
    logic [9:0]    widx;
    logic [3:0]    irq_set;
    logic          irq_r;

    // ========================================
    // receive forwarding and status
    logic          app_valid_r;
    logic [7:0]    app_data_r;
    logic          app_sof_r;
    logic          app_eof_r;
    logic          app_stat_valid_r;
    logic [31:0]   app_stat_r;
    logic          addr_fail_r;
    logic          err_r;
    logic [15:0]   pause_time_r;

    // ========================================
    // sub-block wiring
    logic          p_done;
    logic          p_pause_ok;
    mpfv_quanta_t  p_quanta;
    logic          p_tagged;
    logic          p_too_long;
    logic [15:0]   p_len;
    logic          f_busy;
    logic          f_req;
    logic          f_bp;
    logic          f_hold;
    logic          f_sent;
    logic          tx_enable;
    logic          full_duplex;
    logic          flow_en;

    assign tx_enable   = ctrl_r[`MPFV_CTRL_TXEN];
    assign full_duplex = ctrl_r[`MPFV_CTRL_FDX];
    assign flow_en     = flow_r[`MPFV_FLOW_EN];

    mpfv_rx_parse u_rx (
        .pclk       (pclk),
        .presetn    (presetn),
        .rx_valid   (rx_valid),
        .rx_data    (rx_data),
        .rx_sof     (rx_sof),
        .rx_eof     (rx_eof),
        .rx_err     (rx_err),
        .decode_en  (flow_en && full_duplex),
        .tag_id     (tag1_r),
        .done_r     (p_done),
        .pause_ok_r (p_pause_ok),
        .quanta_r   (p_quanta),
        .tagged_r   (p_tagged),
        .too_long_r (p_too_long),
        .len_r      (p_len)
    );

    mpfv_tx_flow u_tx (
        .pclk            (pclk),
        .presetn         (presetn),
        .tx_enable       (tx_enable),
        .full_duplex     (full_duplex),
        .speed100        (ctrl_r[`MPFV_CTRL_SPD100]),
        .flow_en         (flow_en),
        .send_pause      (ctrl_r[`MPFV_CTRL_SENDP]),
        .bp_request      (ctrl_r[`MPFV_CTRL_BPREQ]),
        .pause_rx        (p_done && p_pause_ok),
        .pause_rx_quanta (p_quanta),
        .pause_tx_done   (pause_tx_done),
        .busy_r          (f_busy),
        .pause_tx_req_r  (f_req),
        .backpressure_r  (f_bp),
        .tx_hold_r       (f_hold),
        .sent_r          (f_sent)
    );

    // ========================================
    // apb slave: answers in the second access cycle
    assign widx    = paddr[11:2];
    assign wr_done = psel && penable && pready_r && pwrite;
    // read taken where prdata is captured, so the clear matches what is returned
    assign rd_done = psel && penable && !pready_r && !pwrite;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (widx)
            10'(`MPFV_IDX_FLOW):     rd_nxt = {flow_r[31:1], f_busy};
            10'(`MPFV_IDX_TAG1):     rd_nxt = {16'h0000, tag1_r};
            10'(`MPFV_IDX_CTRL):     rd_nxt = {27'h000_0000, ctrl_r};
            10'(`MPFV_IDX_STAT):     rd_nxt = {28'h000_0000, f_hold, f_bp, f_req, f_busy};
            10'(`MPFV_IDX_IRQ_STAT): rd_nxt = {28'h000_0000, irq_stat_r};
            10'(`MPFV_IDX_IRQ_MASK): rd_nxt = {28'h000_0000, irq_mask_r};
            default:                 rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel && penable && !pready_r;
            pslverr_r <= psel && penable && !pready_r && !rd_ok;
            if (psel && penable && !pready_r && !pwrite) begin
                prdata_r <= rd_nxt;
            end
        end
    end

    // ========================================
    // software-written registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flow_r <= `MPFV_FLOW_RST;
        end else if (wr_done && widx == 10'(`MPFV_IDX_FLOW)) begin
            // busy never stored from bus
            flow_r <= {pwdata[31:16], 13'h0000, pwdata[2:1], 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tag1_r <= 16'(`MPFV_TAG1_RST);
        end else if (wr_done && widx == 10'(`MPFV_IDX_TAG1)) begin
            tag1_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 5'(`MPFV_CTRL_RST);
        end else if (wr_done && widx == 10'(`MPFV_IDX_CTRL)) begin
            ctrl_r <= pwdata[4:0];
        end else if (f_busy && f_req) begin
            ctrl_r[`MPFV_CTRL_SENDP] <= 1'b0; // one request, one frame
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= 4'h0;
        end else if (wr_done && widx == 10'(`MPFV_IDX_IRQ_MASK)) begin
            irq_mask_r <= pwdata[3:0];
        end
    end

    // ========================================
    // interrupts: pause rx, pause sent, too long, tagged frame
    assign irq_set = {p_done && p_tagged, p_done && p_too_long, f_sent,
                      p_done && p_pause_ok};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= 4'h0;
        end else if (rd_done && widx == 10'(`MPFV_IDX_IRQ_STAT)) begin
            irq_stat_r <= irq_set; // new event beats the read-clear
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_mask_r & ((rd_done && widx == 10'(`MPFV_IDX_IRQ_STAT)) ?
                                     irq_set : (irq_stat_r | irq_set)));
        end
    end

    // ========================================
    // receive forwarding: all frames pass, status decides
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            app_valid_r <= 1'b0;
            app_data_r  <= 8'h00;
            app_sof_r   <= 1'b0;
            app_eof_r   <= 1'b0;
        end else begin
            app_valid_r <= rx_valid;
            app_data_r  <= rx_data;
            app_sof_r   <= rx_valid && rx_sof;
            app_eof_r   <= rx_valid && rx_eof;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_fail_r <= 1'b0;
            err_r       <= 1'b0;
        end else if (rx_valid && rx_eof) begin
            addr_fail_r <= rx_addr_fail;
            err_r       <= rx_err;
        end
    end

    // status follows app_eof by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            app_stat_valid_r <= 1'b0;
            app_stat_r       <= 32'h0000_0000;
        end else begin
            app_stat_valid_r <= p_done;
            if (p_done) begin
                app_stat_r <= {p_len, 11'h000, p_tagged, p_too_long, err_r, addr_fail_r,
                               p_pause_ok && flow_r[`MPFV_FLOW_PASS]};
            end
        end
    end

    // ========================================
    // pause time inserted into sent pause frames
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_time_r <= 16'h0000;
        end else begin
            pause_time_r <= flow_r[31:`MPFV_FLOW_PT_LSB];
        end
    end

    assign pready         = pready_r;
    assign prdata         = prdata_r;
    assign pslverr        = pslverr_r;
    assign app_valid      = app_valid_r;
    assign app_data       = app_data_r;
    assign app_sof        = app_sof_r;
    assign app_eof        = app_eof_r;
    assign app_stat_valid = app_stat_valid_r;
    assign app_stat       = app_stat_r;
    assign pause_tx_req   = f_req;
    assign pause_tx_time  = pause_time_r;
    assign backpressure   = f_bp;
    assign tx_hold        = f_hold;
    assign irq            = irq_r;
endmodule : mpfv_top

// ---- mpfv_chk_assertions.sv ----
/* port checker for mpfv_top.
   assumes one pclk domain. */
`timescale 1ns/100ps
`include "mpfv_consts.svh"
module mpfv_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rx_valid,
    input wire logic        rx_sof,
    input wire logic        app_sof,
    input wire logic [7:0]  rx_data,
    input wire logic        app_valid,
    input wire logic [7:0]  app_data,
    input wire logic        app_eof,
    input wire logic        app_stat_valid,
    input wire logic [31:0] app_stat,
    input wire logic        pause_tx_req,
    input wire logic        pause_tx_done,
    input wire logic        tx_hold
);
    // ========================================
    // properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_app_copy: assert property (rx_valid |=> app_valid && app_data == $past(rx_data) && app_sof == $past(rx_sof))
        else $error("no copy");
    a_app_quiet: assert property (!rx_valid |=> !app_valid)
        else $error("extra byte");
    a_stat_next: assert property (app_eof |=> app_stat_valid)
        else $error("late status");
    a_len_ok: assert property (app_stat_valid && app_stat[31:16] <= `MPFV_MAX_LEN |-> !app_stat[3])
        else $error("legal flagged");
    a_len_long: assert property (app_stat_valid && !app_stat[4] && app_stat[31:16] > `MPFV_MAX_LEN |-> app_stat[3])
        else $error("long frame missed");
    a_hold_cause: assert property ($rose(tx_hold) |-> app_stat_valid)
        else $error("stray hold");
    a_req_hold: assert property (pause_tx_req && !pause_tx_done |=> pause_tx_req)
        else $error("early drop");
    a_req_drop: assert property (pause_tx_req && pause_tx_done |=> !pause_tx_req)
        else $error("request stuck");
    a_ready_one: assert property (pready |=> !pready)
        else $error("ready too long");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("lone error");
    c_filter: cover property (app_stat_valid && app_stat[0]);
    c_sent: cover property (pause_tx_req && pause_tx_done);
    c_hold: cover property ($rose(tx_hold));
endmodule : mpfv_chk

// ---- mpfv_link_model.sv ----
/* MAC transmitter model: done lat+1 clocks after each pause request.
   assumes lat steady per request. */
`timescale 1ns/100ps
module mpfv_link_model (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [7:0] lat,
    input wire logic       pause_tx_req,
    output logic           pause_tx_done
);
    // ========================================
    // done pulse, one per request
    logic [7:0] cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r         <= 8'h00;
            pause_tx_done <= 1'b0;
        end else begin
            cnt_r         <= (pause_tx_req && !pause_tx_done) ? cnt_r + 8'h01 : 8'h00;
            pause_tx_done <= pause_tx_req && !pause_tx_done && cnt_r == lat;
        end
    end
endmodule : mpfv_link_model

// ---- mpfv_tb.sv ----
/* self-checking bench for mpfv_top.
   assumes a 100 ns pclk. */
`timescale 1ns/100ps
`include "mpfv_consts.svh"
module testbench;
    import mpfv_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, er, af;
    logic        rx_valid, rx_sof, rx_eof, rx_err, rx_addr_fail, app_valid, app_sof, app_eof;
    logic        app_stat_valid, pause_tx_done, pause_tx_req, backpressure, tx_hold, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, stat_q, app_stat;
    logic [7:0]  rx_data, app_data, lat;
    logic [15:0] pause_tx_time, q;
    int          n_fail, cmp_count, seed, hold_n, ticks;
    mpfv_top uut (.*);
    mpfv_link_model u_link (.*);
    // ========================================
    // helpers
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; err_q = pslverr; psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    function logic [7:0] fb(input int i, input logic [15:0] ty);
        logic [143:0] h;
        h = {`MPFV_PAUSE_DA, 48'h0000_0000_0000, ty, `MPFV_PAUSE_OPC, q};
        return (i < 18) ? h[143-8*i -: 8] : 8'($random(seed));
    endfunction : fb
    task frame(input logic [15:0] ty, input int len);
        for (int i = 0; i < len; i++) begin
            @(posedge pclk);
            rx_valid <= 1'b1; rx_sof <= (i == 0); rx_eof <= (i == len - 1);
            rx_err <= er; rx_addr_fail <= af; rx_data <= fb(i, ty);
        end
        @(posedge pclk) rx_valid <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : frame
    task conclude;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // ========================================
    // clock, watchdog, status capture
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        ticks <= ticks + 1;
        if (app_stat_valid) stat_q <= app_stat;
        hold_n <= rx_sof ? 0 : hold_n + int'(tx_hold);
        if (ticks == 30000) begin
            n_fail++;
            conclude();
        end
    end
    // ========================================
    // sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, rx_valid, rx_sof} = '0;
        {rx_eof, rx_err, rx_addr_fail, rx_data, er, af} = '0;
        seed = 32'h46d6_cf50; ticks = 0; hold_n = 0; lat = 8'h02;
        n_fail = 0; cmp_count = 0;
        q = {14'h0000, 2'($random(seed))} | 16'h0001;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 12'h020, 0); chk(rd, `MPFV_FLOW_RST);
        apb(0, 12'h024, 0); chk(rd, `MPFV_TAG1_RST);
        apb(0, 12'h07C, 0); chk(32'(err_q), 32'h0000_0001);
        apb(1, 12'h024, 32'h0000_8100);
        apb(1, 12'h04C, 32'h0000_0001);
        apb(1, 12'h040, 32'h0000_0007);
        apb(1, 12'h020, {q, 16'h0006});
        apb(0, 12'h020, 0); chk(rd, {q, 16'h0006});
        frame(`MPFV_PAUSE_TYPE, 64); chk(32'(stat_q[0]), 1);
        chk(32'(irq), 1);
        apb(0, 12'h048, 0); chk(32'(rd[0]), 1);
        repeat (52 * 3) @(posedge pclk); chk(32'(irq), 0);
        chk(32'(hold_n), 32'(`MPFV_SLOT_CYC_100 * q));
        $display("test pause receive done");
        apb(1, 12'h020, {q, 16'h0002});
        frame(`MPFV_PAUSE_TYPE, 64); chk(32'(stat_q[0]), 0);
        repeat (160) @(posedge pclk);
        apb(1, 12'h020, {q, 16'h0000});
        frame(`MPFV_PAUSE_TYPE, 64); chk(32'(hold_n), 0);
        frame(16'h8100, 1522); chk(stat_q, {16'd1522, 16'h0010});
        er = 1'($random(seed)); af = 1'($random(seed));
        frame(16'h0800, 1519); chk(stat_q, {16'd1519, 11'h000, 2'b01, er, af, 1'b0});
        er = 1'b0; af = 1'b0;
        $display("test status done");
        lat <= 8'($random(seed)) & 8'h07;
        apb(1, 12'h040, 32'h0000_000F);
        while (pause_tx_req !== 1'b1) @(posedge pclk);
        chk(32'(pause_tx_time), 32'(q));
        while (pause_tx_req !== 1'b0) @(posedge pclk);
        apb(0, 12'h044, 0); chk(32'(rd[0]), 0);
        apb(1, 12'h040, 32'h0000_000A);
        repeat (3) @(posedge pclk); chk(32'(pause_tx_req), 0);
        apb(1, 12'h020, {q, 16'h0002});
        apb(1, 12'h040, 32'h0000_0011);
        repeat (2) @(posedge pclk); chk(32'(backpressure), 1);
        apb(0, 12'h044, 0); chk(32'(rd[0]), 1);
        apb(1, 12'h040, 32'h0000_0010);
        repeat (2) @(posedge pclk); chk(32'(backpressure), 0);
        $display("test pause send done");
        conclude();
    end
endmodule : testbench
bind mpfv_top mpfv_chk u_chk (.*);
